// ===== hw/usb2_frontend_test_regs.sv
// Test and control register bank for the USB 2.0 analog front end.
// Assumes an APB master on pclk, analog status inputs that are asynchronous,
// and a configuration loader on pclk that presents trim images with a strobe.
//
// Function
// - Full/low-speed drive enable is active low; one tri-states the driver.
// - Positive output bit gives the level driven on D+.
// - Negative output bit gives the level driven on D-.
// - Read-only bit shows the full/low-speed receiver; writes are ignored.
// - Valid mask 00 none, 01 low bit, 11 both; 10 is invalid.
// - High-speed transmit bits go to the line low bit first.
// - Current source bit powers the driver; forced on in high-speed mode.
// - Drive trim codes select nominal or a fixed percentage step.
// - Drive trim loads from EEPROM, else OTP, else zero at initialisation.
// - USB or lite reset restores drive trim to EEPROM image or zero.
// - Reset protection keeps both trims across the guarded resets.
// - Two bits switch on the pull-ups for D+ and D-.
// - Two bits switch on the pull-downs for D+ and D-.
// - Driver active bit selects low-power idle or active transmit.
// - Termination bit switches high-speed termination on both lines.
// - Read-only squelch bit reads one for valid data, zero for invalid.
// - Read-only disconnect bit is one on a disconnect, read at EOP.
// - Squelch trim codes lower or raise the trip point in fixed steps.
// - Squelch trim loads from EEPROM, else OTP, else zero at initialisation.
// - USB or lite reset restores squelch trim to its image or zero.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module usb2_frontend_test_regs
    import usb2_frontend_pkg::*;
(
    input wire logic pclk, // Register clock, 250 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB write byte strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic cfg_load, // Pulse: configuration images are valid.
    input wire logic cfg_eeprom_present, // An EEPROM supplied the image.
    input wire logic cfg_otp_programmed, // OTP holds programmed trims.
    input wire logic [2:0] stored_drive_trim_flag, // Drive trim from EEPROM.
    input wire logic [2:0] stored_squelch_flag, // Squelch trim from EEPROM.
    input wire logic [2:0] otp_drive_trim, // Drive trim from OTP.
    input wire logic [2:0] otp_squelch_trim, // Squelch trim from OTP.
    input wire logic usb_reset, // Pulse: USB bus reset seen.
    input wire logic lite_reset, // Pulse: lite reset requested.
    input wire logic reset_protect, // Level: trims survive guarded resets.
    input wire logic highspeed_mode, // Level: port runs in high-speed mode.
    input wire line_status_s line_status_raw, // Asynchronous analog status.
    output fs_drive_s fs_drive, // Full/low-speed driver override.
    output termination_s termination, // Line termination switches.
    output logic [1:0] frontend_tx_valid_bus, // Decoded transmit valid bits.
    output logic highspeed_tx_bit, // Serial high-speed transmit data.
    output logic highspeed_tx_bit_valid, // Serial data qualifier.
    output logic highspeed_current_source_on, // Current source power.
    output logic highspeed_driver_active, // Driver out of low-power mode.
    output logic [2:0] drive_current_trim, // Output current trim code.
    output logic [2:0] squelch_trip_trim // Squelch trip-point trim code.
);

    // ==========================================================
    // Helper functions

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Valid mask decode; the invalid code marks no bit valid.
    function automatic logic [1:0] decode_valid(input logic [1:0] mask);
        return (mask == VALID_MASK_BAD) ? 2'h0 : mask;
    endfunction

    // Trim image choice at initialisation: EEPROM, then OTP, then zero.
    function automatic logic [2:0] pick_image(input logic eeprom,
                                              input logic otp,
                                              input logic [2:0] from_eeprom,
                                              input logic [2:0] from_otp);
        if (eeprom) begin
            return from_eeprom;
        end
        return otp ? from_otp : TRIM_RESET;
    endfunction

    // ==========================================================
    // Status synchroniser

    line_status_s sync1_q, sync2_q, sync3_q, status_q;

    // Three stages; a change is taken once stages two and three agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            status_q <= '0;
        end else begin
            sync1_q <= line_status_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < 3; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    status_q[i] <= sync3_q[i];
                end
            end
        end
    end

    // ==========================================================
    // APB front end

    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic hit_test, hit_ctrl, wr_fire;
    logic [31:0] test_rd, ctrl_rd;

    assign hit_test = (paddr == TEST_REG_OFFSET);
    assign hit_ctrl = (paddr == CTRL_REG_OFFSET);
    // A write lands only on the access edge that sees pready high.
    assign wr_fire = psel && penable && pready_q && pwrite;

    // The answer is prepared in the setup cycle, so the access phase
    // completes at its first edge and never needs a wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !(hit_test || hit_ctrl);
            if (psel && !penable && !pwrite) begin
                prdata_q <= hit_test ? test_rd : (hit_ctrl ? ctrl_rd : '0);
            end else begin
                prdata_q <= '0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ==========================================================
    // Stored control fields

    fs_drive_s fs_q;
    termination_s term_q;
    logic [1:0] valid_mask_q;
    logic [1:0] tx_bits_q;
    logic cs_bit_q, active_q;
    logic [31:0] test_wr, ctrl_wr;

    assign test_wr = merge_lanes(test_rd, pwdata, pstrb);
    assign ctrl_wr = merge_lanes(ctrl_rd, pwdata, pstrb);

    // Plain read/write override bits of both registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_q <= '{enable_n: FS_DRIVE_EN_N_RESET, pos: 1'b0, neg: 1'b0};
            term_q <= '0;
            valid_mask_q <= VALID_MASK_RESET;
            tx_bits_q <= 2'h0;
            cs_bit_q <= 1'b0;
            active_q <= 1'b0;
        end else if (wr_fire && hit_test) begin
            fs_q.enable_n <= test_wr[FS_DRIVE_EN_N_BIT];
            fs_q.pos <= test_wr[FS_POS_OUT_BIT];
            fs_q.neg <= test_wr[FS_NEG_OUT_BIT];
            valid_mask_q <= test_wr[HS_VALID_MASK_LSB +: 2];
            tx_bits_q <= test_wr[HS_TX_BITS_LSB +: 2];
            cs_bit_q <= test_wr[HS_CS_ON_BIT];
            term_q.pullup_plus <= test_wr[PULLUP_PLUS_BIT];
            term_q.pullup_minus <= test_wr[PULLUP_MINUS_BIT];
            term_q.pulldown_plus <= test_wr[PULLDOWN_PLUS_BIT];
            term_q.pulldown_minus <= test_wr[PULLDOWN_MINUS_BIT];
            active_q <= test_wr[HS_DRIVER_ACTIVE_BIT];
        end else if (wr_fire && hit_ctrl) begin
            term_q.highspeed <= ctrl_wr[HS_TERM_ON_BIT];
        end
    end

    // ==========================================================
    // Trims with configuration images

    logic [2:0] drive_trim_q, squelch_trim_q;
    logic [2:0] drive_image_q, squelch_image_q;
    logic guarded_reset;

    // Reset protection shields the trims from USB and lite resets.
    assign guarded_reset = (usb_reset || lite_reset) && !reset_protect;

    // Images remembered for restore; the drive trim restore only knows
    // the EEPROM, so an OTP value is not brought back for it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_image_q <= TRIM_RESET;
            squelch_image_q <= TRIM_RESET;
        end else if (cfg_load) begin
            drive_image_q <= cfg_eeprom_present ? stored_drive_trim_flag
                                                : TRIM_RESET;
            squelch_image_q <= pick_image(cfg_eeprom_present, cfg_otp_programmed,
                                          stored_squelch_flag,
                                          otp_squelch_trim);
        end
    end

    // Load beats restore, restore beats a software write in one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_trim_q <= TRIM_RESET;
        end else if (cfg_load) begin
            drive_trim_q <= pick_image(cfg_eeprom_present, cfg_otp_programmed,
                                       stored_drive_trim_flag,
                                       otp_drive_trim);
        end else if (guarded_reset) begin
            drive_trim_q <= drive_image_q;
        end else if (wr_fire && hit_test) begin
            drive_trim_q <= test_wr[DRIVE_TRIM_LSB +: 3];
        end
    end

    // Same ordering for the squelch trim.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            squelch_trim_q <= TRIM_RESET;
        end else if (cfg_load) begin
            squelch_trim_q <= pick_image(cfg_eeprom_present, cfg_otp_programmed,
                                         stored_squelch_flag,
                                         otp_squelch_trim);
        end else if (guarded_reset) begin
            squelch_trim_q <= squelch_image_q;
        end else if (wr_fire && hit_ctrl) begin
            squelch_trim_q <= ctrl_wr[SQUELCH_TRIM_LSB +: 3];
        end
    end

    // ==========================================================
    // Read-back words

    // Everything not assigned below reads as zero.
    always_comb begin
        test_rd = '0;
        test_rd[FS_DRIVE_EN_N_BIT] = fs_q.enable_n;
        test_rd[FS_POS_OUT_BIT] = fs_q.pos;
        test_rd[FS_NEG_OUT_BIT] = fs_q.neg;
        test_rd[FS_RX_LEVEL_BIT] = status_q.rx_level;
        test_rd[HS_VALID_MASK_LSB +: 2] = valid_mask_q;
        test_rd[HS_TX_BITS_LSB +: 2] = tx_bits_q;
        test_rd[HS_CS_ON_BIT] = cs_bit_q || highspeed_mode;
        test_rd[DRIVE_TRIM_LSB +: 3] = drive_trim_q;
        test_rd[PULLUP_PLUS_BIT] = term_q.pullup_plus;
        test_rd[PULLUP_MINUS_BIT] = term_q.pullup_minus;
        test_rd[PULLDOWN_PLUS_BIT] = term_q.pulldown_plus;
        test_rd[PULLDOWN_MINUS_BIT] = term_q.pulldown_minus;
        test_rd[HS_DRIVER_ACTIVE_BIT] = active_q;
    end

    // Status bits are only observed here; the reader must pick its moment.
    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[HS_TERM_ON_BIT] = term_q.highspeed;
        ctrl_rd[SQUELCH_INVALID_N_BIT] = status_q.squelch_invalid_n;
        ctrl_rd[HS_DISCONNECT_BIT] = status_q.disconnect_seen;
        ctrl_rd[SQUELCH_TRIM_LSB +: 3] = squelch_trim_q;
    end

    // ==========================================================
    // Drive outputs

    logic phase_q, tx_bit_q, tx_bit_valid_q, cs_on_q;
    logic [1:0] valid_bus_q;
    logic [1:0] valid_dec;

    // Decoded once here, because a function result cannot be indexed directly.
    assign valid_dec = decode_valid(valid_mask_q);

    // Two-bit word leaves one bit per clock, low bit first; phase only
    // runs while the driver is active so the first word after activation starts on bit zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 1'b0;
            tx_bit_q <= 1'b0;
            tx_bit_valid_q <= 1'b0;
        end else begin
            phase_q <= active_q ? !phase_q : 1'b0;
            tx_bit_q <= tx_bits_q[phase_q];
            tx_bit_valid_q <= active_q && valid_dec[phase_q];
        end
    end

    // Current source follows the bit, high-speed mode and transmit activity.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_on_q <= 1'b0;
            valid_bus_q <= 2'h0;
        end else begin
            cs_on_q <= cs_bit_q || highspeed_mode || active_q;
            valid_bus_q <= valid_dec;
        end
    end

    assign fs_drive = fs_q;
    assign termination = term_q;
    assign frontend_tx_valid_bus = valid_bus_q;
    assign highspeed_tx_bit = tx_bit_q;
    assign highspeed_tx_bit_valid = tx_bit_valid_q;
    assign highspeed_current_source_on = cs_on_q;
    assign highspeed_driver_active = active_q;
    assign drive_current_trim = drive_trim_q;
    assign squelch_trip_trim = squelch_trim_q;

    // ==========================================================
    // Assertions

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_fs_enable_write: assert property (
        wr_fire && hit_test && pstrb[2] |=> fs_drive.enable_n == $past(pwdata[22]))
        else $error("driver enable did not take the written bit");

    a_fs_pos_write: assert property (
        wr_fire && hit_test && pstrb[2] |=> fs_drive.pos == $past(pwdata[21]))
        else $error("positive output did not take the written bit");

    a_rx_read_only: assert property (
        psel && !penable && !pwrite && hit_test |=> prdata[19] == $past(status_q.rx_level))
        else $error("receiver bit read back wrong");

    a_bad_mask_none: assert property (
        valid_mask_q == VALID_MASK_BAD |=> frontend_tx_valid_bus == 2'h0)
        else $error("invalid mask marked bits valid");

    a_lsb_first_out: assert property (
        active_q && !phase_q && $stable(tx_bits_q) |=> highspeed_tx_bit == $past(tx_bits_q[0]))
        else $error("first serial bit is not the low bit");

    a_hs_mode_cs: assert property (
        highspeed_mode |=> highspeed_current_source_on)
        else $error("current source off in high-speed mode");

    a_drive_restore: assert property (
        guarded_reset && !cfg_load |=> drive_current_trim == $past(drive_image_q))
        else $error("drive trim not restored");

    a_protect_holds: assert property (
        (usb_reset || lite_reset) && reset_protect && !cfg_load && !wr_fire
        |=> $stable(drive_current_trim) && $stable(squelch_trip_trim))
        else $error("protected trim changed on reset");

    a_squelch_load: assert property (
        cfg_load |=> squelch_trip_trim == $past(pick_image(cfg_eeprom_present,
            cfg_otp_programmed, stored_squelch_flag, otp_squelch_trim)))
        else $error("squelch trim not loaded from image");

    a_reserved_zero: assert property (
        pready && psel && penable && !pwrite
        |-> (prdata & 32'hff87_000d & {32{hit_test}}) == 32'h0
        && (prdata & 32'hc0ff_ffff & {32{hit_ctrl}}) == 32'h0)
        else $error("reserved bits read nonzero");

    a_one_cycle_ready: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");

    c_test_write: cover property (wr_fire && hit_test);
    c_ctrl_read: cover property (psel && penable && pready && !pwrite && hit_ctrl);
    c_guarded_restore: cover property (guarded_reset ##1 drive_current_trim != 3'h0);
    c_unmapped: cover property (pslverr);

endmodule

// ===== shared/usb2_frontend_pkg.sv
// Package for the USB 2.0 front-end test and control register bank.
// Assumes an APB slave with 12-bit byte addresses and 32-bit data.
package usb2_frontend_pkg;

    // ==========================================================
    // Register map
    localparam logic [11:0] TEST_REG_OFFSET = 12'h0c4;
    localparam logic [11:0] CTRL_REG_OFFSET = 12'h0c8;

    // ==========================================================
    // Field positions of the test register
    localparam int FS_DRIVE_EN_N_BIT = 22;
    localparam int FS_POS_OUT_BIT = 21;
    localparam int FS_NEG_OUT_BIT = 20;
    localparam int FS_RX_LEVEL_BIT = 19;
    localparam int HS_VALID_MASK_LSB = 14;
    localparam int HS_TX_BITS_LSB = 12;
    localparam int HS_CS_ON_BIT = 11;
    localparam int DRIVE_TRIM_LSB = 8;
    localparam int PULLUP_PLUS_BIT = 7;
    localparam int PULLUP_MINUS_BIT = 6;
    localparam int PULLDOWN_PLUS_BIT = 5;
    localparam int PULLDOWN_MINUS_BIT = 4;
    localparam int HS_DRIVER_ACTIVE_BIT = 1;

    // ==========================================================
    // Field positions of the upstream control register
    localparam int HS_TERM_ON_BIT = 29;
    localparam int SQUELCH_INVALID_N_BIT = 28;
    localparam int HS_DISCONNECT_BIT = 27;
    localparam int SQUELCH_TRIM_LSB = 24;

    // ==========================================================
    // Reset values and encodings
    localparam logic [2:0] TRIM_RESET = 3'h0;
    localparam logic [1:0] VALID_MASK_RESET = 2'h0;
    localparam logic [1:0] VALID_MASK_BAD = 2'h2;
    localparam logic FS_DRIVE_EN_N_RESET = 1'b0;
    localparam int SYNC_STAGES = 3;

    // Full/low-speed driver override bundle.
    typedef struct packed {
        logic enable_n;
        logic pos;
        logic neg;
    } fs_drive_s;

    // Line termination bundle.
    typedef struct packed {
        logic pullup_plus;
        logic pullup_minus;
        logic pulldown_plus;
        logic pulldown_minus;
        logic highspeed;
    } termination_s;

    // Analog status bundle, in the order of the synchroniser.
    typedef struct packed {
        logic rx_level;
        logic squelch_invalid_n;
        logic disconnect_seen;
    } line_status_s;

endpackage

// ===== test/usb2_frontend_test_regs_test.sv
// Self-checking bench for the USB 2.0 front-end test and control register bank.
// Assumes the bank is the only APB slave and drives its own pready; no partner model.
`timescale 1ns/1ps
module usb2_frontend_test_regs_test
    import usb2_frontend_pkg::*;
();
    // ==========================================================
    // Stimulus signals are given a value at time zero; observed signals are not.
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hf;
    logic cfg_load = 1'b0, cfg_eeprom_present = 1'b0, cfg_otp_programmed = 1'b0;
    logic [2:0] stored_drive_trim_flag = 3'h5, stored_squelch_flag = 3'h6;
    logic [2:0] otp_drive_trim = 3'h3, otp_squelch_trim = 3'h2;
    logic usb_reset = 1'b0, lite_reset = 1'b0, reset_protect = 1'b0, highspeed_mode = 1'b0;
    line_status_s line_status_raw = 3'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    fs_drive_s fs_drive;
    termination_s termination;
    logic [1:0] frontend_tx_valid_bus;
    logic highspeed_tx_bit, highspeed_tx_bit_valid;
    logic highspeed_current_source_on, highspeed_driver_active;
    logic [2:0] drive_current_trim, squelch_trip_trim;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int n_tests = 0;
    int seen;
    // Expected trims per load case: EEPROM, OTP only, neither.
    logic [2:0] load_drive[3] = '{3'h5, 3'h3, 3'h0};
    logic [2:0] load_squelch[3] = '{3'h6, 3'h2, 3'h0};
    logic [2:0] back_drive[3] = '{3'h5, 3'h0, 3'h0};

    usb2_frontend_test_regs i_usb2_frontend_test_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_load(cfg_load), .cfg_eeprom_present(cfg_eeprom_present),
        .cfg_otp_programmed(cfg_otp_programmed), .stored_drive_trim_flag(stored_drive_trim_flag),
        .stored_squelch_flag(stored_squelch_flag), .otp_drive_trim(otp_drive_trim),
        .otp_squelch_trim(otp_squelch_trim), .usb_reset(usb_reset), .lite_reset(lite_reset),
        .reset_protect(reset_protect), .highspeed_mode(highspeed_mode),
        .line_status_raw(line_status_raw), .fs_drive(fs_drive), .termination(termination),
        .frontend_tx_valid_bus(frontend_tx_valid_bus), .highspeed_tx_bit(highspeed_tx_bit),
        .highspeed_tx_bit_valid(highspeed_tx_bit_valid),
        .highspeed_current_source_on(highspeed_current_source_on),
        .highspeed_driver_active(highspeed_driver_active),
        .drive_current_trim(drive_current_trim), .squelch_trip_trim(squelch_trip_trim)
    );

    // Free-running register clock at 250 MHz.
    always #2 pclk = ~pclk;

    // ==========================================================
    // Shared tasks: verdict, compare, APB transfer, config load, guarded reset.
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask

    // Ready and read data are taken at the rising edge that samples pready high;
    // the request stands unchanged until that edge and is released right after it.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                finish_test();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic load(input logic e, input logic o);
        @(posedge pclk);
        cfg_eeprom_present <= e;
        cfg_otp_programmed <= o;
        cfg_load <= 1'b1;
        @(posedge pclk);
        cfg_load <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic guard(input logic lite, input logic prot);
        @(posedge pclk);
        usb_reset <= ~lite;
        lite_reset <= lite;
        reset_protect <= prot;
        @(posedge pclk);
        usb_reset <= 1'b0;
        lite_reset <= 1'b0;
        reset_protect <= 1'b0;
        @(negedge pclk);
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(TEST_REG_OFFSET, 32'h0);
        rdchk(CTRL_REG_OFFSET, 32'h0);
        // All ones: read-only and reserved places must stay clear.
        apb(1'b1, TEST_REG_OFFSET, 32'hffffffff);
        @(negedge pclk);
        chk(32'(fs_drive), 32'h7);
        chk(32'(termination), 32'h1e);
        chk(32'(highspeed_driver_active), 32'h1);
        chk(32'(drive_current_trim), 32'h7);
        rdchk(TEST_REG_OFFSET, 32'h0070fff2);
        apb(1'b1, CTRL_REG_OFFSET, 32'hffffffff);
        rdchk(CTRL_REG_OFFSET, 32'h27000000);
        chk(32'(termination.highspeed), 32'h1);
        chk(32'(squelch_trip_trim), 32'h7);
        // Only byte lane one is strobed, so only bits 15:8 clear.
        pstrb <= 4'h2;
        apb(1'b1, TEST_REG_OFFSET, 32'h0);
        pstrb <= 4'hf;
        rdchk(TEST_REG_OFFSET, 32'h007000f2);
        apb(1'b1, 12'h0cc, 32'hffffffff);
        chk(32'(err), 32'h1);
        rdchk(12'h0cc, 32'h0);
        apb(1'b1, TEST_REG_OFFSET, 32'h00200000);
        @(negedge pclk);
        chk(32'(fs_drive), 32'h2);
        @(posedge pclk);
        highspeed_mode <= 1'b1;
        repeat (2) @(negedge pclk);
        chk(32'(highspeed_current_source_on), 32'h1);
        rdchk(TEST_REG_OFFSET, 32'h00200800);
        highspeed_mode <= 1'b0;
        // Every mask code, the invalid one included.
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, TEST_REG_OFFSET, 32'(i) << 14);
            repeat (2) @(negedge pclk);
            chk(32'(frontend_tx_valid_bus), (i == 2) ? 32'h0 : 32'(i));
        end
        // Only the low bit is valid, so every valid serial bit must be tx bit 0.
        for (int b = 1; b < 3; b++) begin
            seen = 0;
            apb(1'b1, TEST_REG_OFFSET, 32'h00004002 | (32'(b) << 12));
            repeat (12) begin
                @(negedge pclk);
                if (highspeed_tx_bit_valid === 1'b1) begin
                    seen++;
                    chk(32'(highspeed_tx_bit), 32'(b & 1));
                end
            end
            chk(32'(seen > 0), 32'h1);
        end
        apb(1'b1, TEST_REG_OFFSET, 32'h0);
        repeat (3) @(negedge pclk);
        chk(32'(highspeed_tx_bit_valid), 32'h0);
        // Status inputs cross a synchroniser before they show.
        @(posedge pclk);
        line_status_raw <= 3'h7;
        repeat (8) @(posedge pclk);
        rdchk(TEST_REG_OFFSET, 32'h00080000);
        rdchk(CTRL_REG_OFFSET, 32'h3f000000);
        line_status_raw <= 3'h0;
        repeat (8) @(posedge pclk);
        rdchk(CTRL_REG_OFFSET, 32'h27000000);
        // Load, protected reset, then unprotected restore for each source case.
        for (int k = 0; k < 3; k++) begin
            load(k == 0, k < 2);
            chk(32'(drive_current_trim), 32'(load_drive[k]));
            chk(32'(squelch_trip_trim), 32'(load_squelch[k]));
            apb(1'b1, TEST_REG_OFFSET, 32'h00000700);
            apb(1'b1, CTRL_REG_OFFSET, 32'h07000000);
            guard(k == 1, 1'b1);
            chk(32'(drive_current_trim), 32'h7);
            chk(32'(squelch_trip_trim), 32'h7);
            guard(k != 1, 1'b0);
            chk(32'(drive_current_trim), 32'(back_drive[k]));
            chk(32'(squelch_trip_trim), 32'(load_squelch[k]));
            rdchk(TEST_REG_OFFSET, {21'h0, back_drive[k], 8'h0});
        end
        finish_test();
    end
endmodule
